// file: core/tcg_timer.sv
// timer control, gate selection and count registers behind an ahb-lite slave
//
// The AHB-Lite register port and the register addresses are this design's own decisions.
`timescale 1ns/100ps
module tcg_timer #(
  parameter int CNT_W = 16
) (
  // clock and reset
  input  wire logic              hclk,
  input  wire logic              hresetn,
  // ahb-lite slave
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic                   hreadyout,
  output logic                   hresp,
  output logic [31:0]            hrdata,
  // timer pins
  input  wire logic              external_clock_pin,
  input  wire logic              gate_pin_n,
  input  wire logic              second_comparator_output,
  // status
  output logic                   low_power_osc_enable,
  output logic [CNT_W-1:0]       count_value
);

  logic [7:0]       ctrl_reg;
  logic [7:0]       gate_sel_reg;
  logic [CNT_W-1:0] count_reg;
  logic [CNT_W-1:0] count_next;
  logic [2:0]       presc_reg;
  logic [1:0]       div_reg;
  logic             ext_s1_reg, ext_s2_reg, ext_s3_reg;
  logic             gp_s1_reg, gp_s2_reg;
  logic             cmp_s1_reg, cmp_s2_reg;
  logic             armed_reg;
  logic             pend_reg;
  logic             run_d_reg;
  logic             wr_pend_reg;
  logic [7:0]       wr_addr_reg;
  logic [31:0]      rdata_reg;

  // bus decode
  logic       addr_take;
  logic       wr_now;
  logic       wr_ctrl, wr_low, wr_high, wr_gsel, wr_count;

  assign addr_take = hsel && hready && (htrans == tcg_pkg::HTRANS_NONSEQ ||
                                        htrans == tcg_pkg::HTRANS_SEQ);
  assign wr_now   = wr_pend_reg;
  assign wr_ctrl  = wr_now && wr_addr_reg == tcg_pkg::CTRL_OFS;
  assign wr_low   = wr_now && wr_addr_reg == tcg_pkg::CNT_LOW_OFS;
  assign wr_high  = wr_now && wr_addr_reg == tcg_pkg::CNT_HIGH_OFS;
  assign wr_gsel  = wr_now && wr_addr_reg == tcg_pkg::GATE_SEL_OFS;
  assign wr_count = wr_low || wr_high;

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = rdata_reg;

  function automatic logic [31:0] read_mux(input logic [7:0] a);
    case (a)
      tcg_pkg::CTRL_OFS:     read_mux = {24'h000000, ctrl_reg};
      tcg_pkg::CNT_LOW_OFS:  read_mux = {24'h000000, count_reg[7:0]};
      tcg_pkg::CNT_HIGH_OFS: read_mux = {24'h000000, count_reg[CNT_W-1 -: 8]};
      tcg_pkg::GATE_SEL_OFS: read_mux = {24'h000000, gate_sel_reg};
      default:               read_mux = 32'h00000000;
    endcase
  endfunction

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
    end else begin
      wr_pend_reg <= addr_take && hwrite;
      if (addr_take) begin
        wr_addr_reg <= haddr[7:0];
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdata_reg <= 32'h00000000;
    end else if (addr_take && !hwrite) begin
      rdata_reg <= read_mux(haddr[7:0]);
    end
  end

  // control registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_reg     <= tcg_pkg::CTRL_RESET;
      gate_sel_reg <= tcg_pkg::GATE_SEL_RESET;
    end else begin
      if (wr_ctrl) begin
        ctrl_reg <= hwdata[7:0];
      end
      if (wr_gsel) begin
        gate_sel_reg <= hwdata[7:0] & (8'h01 << tcg_pkg::GSS_BIT);
      end
    end
  end

  logic       run, cs, sync_dis, ge, inv, gss;
  logic [1:0] ps;
  assign run      = ctrl_reg[tcg_pkg::CTRL_RUN_BIT];
  assign cs       = ctrl_reg[tcg_pkg::CTRL_CS_BIT];
  assign sync_dis = ctrl_reg[tcg_pkg::CTRL_SYNCDIS_BIT];
  assign ge       = ctrl_reg[tcg_pkg::CTRL_GE_BIT];
  assign inv      = ctrl_reg[tcg_pkg::CTRL_INV_BIT];
  assign ps       = ctrl_reg[tcg_pkg::CTRL_PS_LSB +: 2];
  assign gss      = gate_sel_reg[tcg_pkg::GSS_BIT];
  assign low_power_osc_enable = ctrl_reg[tcg_pkg::CTRL_OSCEN_BIT];
  assign count_value          = count_reg;

  // pin synchronisers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ext_s1_reg <= 1'b0;
      ext_s2_reg <= 1'b0;
      ext_s3_reg <= 1'b0;
      gp_s1_reg  <= 1'b1;
      gp_s2_reg  <= 1'b1;
      cmp_s1_reg <= 1'b0;
      cmp_s2_reg <= 1'b0;
    end else begin
      ext_s1_reg <= external_clock_pin;
      ext_s2_reg <= ext_s1_reg;
      ext_s3_reg <= ext_s2_reg;
      gp_s1_reg  <= gate_pin_n;
      gp_s2_reg  <= gp_s1_reg;
      cmp_s1_reg <= second_comparator_output;
      cmp_s2_reg <= cmp_s1_reg;
    end
  end

  // instruction clock tick
  logic instr_tick;
  assign instr_tick = div_reg == tcg_pkg::INSTR_DIV_LAST;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_reg <= 2'h0;
    end else begin
      div_reg <= div_reg + 2'h1;
    end
  end

  // external edges; a falling edge must be seen before the first counted rise
  logic ext_rise, ext_fall, ext_ok;
  assign ext_rise = ext_s2_reg && !ext_s3_reg;
  assign ext_fall = !ext_s2_reg && ext_s3_reg;
  assign ext_ok   = ext_rise && armed_reg;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      armed_reg <= 1'b0;
      run_d_reg <= 1'b0;
    end else begin
      run_d_reg <= run;
      if (ext_fall) begin
        armed_reg <= 1'b1;
      end else if (wr_count || (run && !run_d_reg)) begin
        armed_reg <= 1'b0;
      end
    end
  end

  // synchronous mode holds the edge until the next instruction tick
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pend_reg <= 1'b0;
    end else if (ext_ok) begin
      pend_reg <= 1'b1;
    end else if (instr_tick || wr_count) begin
      pend_reg <= 1'b0;
    end
  end

  logic src_tick;
  always_comb begin
    if (!cs) begin
      src_tick = instr_tick;
    end else if (sync_dis) begin
      src_tick = ext_ok;
    end else begin
      src_tick = pend_reg && instr_tick;
    end
  end

  // gate
  logic gate_raw, gate_open, count_en;
  assign gate_raw  = gss ? cmp_s2_reg : gp_s2_reg;
  assign gate_open = inv ? gate_raw : !gate_raw;
  assign count_en  = run && (!ge || gate_open);

  // prescaler, cleared by any count write
  logic       presc_tick;
  logic [2:0] presc_last;
  assign presc_last = 3'((4'h1 << ps) - 4'h1);
  // a ratio cut below the current phase ends the period at the next tick
  assign presc_tick = count_en && src_tick && presc_reg >= presc_last;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      presc_reg <= 3'h0;
    end else if (wr_count || presc_tick) begin
      presc_reg <= 3'h0;
    end else if (count_en && src_tick) begin
      presc_reg <= presc_reg + 3'h1;
    end
  end

  // count; a written byte takes precedence over the increment of that byte, the other byte takes its byte of the incremented count
  always_comb begin
    count_next = count_reg;
    if (presc_tick) begin
      count_next = count_reg + CNT_W'(1);
    end
    if (wr_low) begin
      count_next[7:0] = hwdata[7:0];
    end
    if (wr_high) begin
      count_next[CNT_W-1 -: 8] = hwdata[7:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count_reg <= tcg_pkg::COUNT_RESET;
    end else begin
      count_reg <= count_next;
    end
  end

  // checks
  run_stops_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !run && !wr_count |=> count_reg == $past(count_reg))
    else $error("count moved while stopped");

  gate_ignored_a: assert property (@(posedge hclk) disable iff (!hresetn)
    run && !ge && src_tick && !wr_count && presc_reg == presc_last
    |=> count_reg == $past(count_reg) + CNT_W'(1))
    else $error("ungated count missed increment");

  gate_closed_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ge && !gate_open && !wr_count |=> count_reg == $past(count_reg))
    else $error("count moved with gate closed");

  gate_source_a: assert property (@(posedge hclk) disable iff (!hresetn)
    gss && run && ge && !inv && cmp_s2_reg && !wr_count
    |=> count_reg == $past(count_reg))
    else $error("comparator gate not honoured");

  gate_select_a: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_gsel |=> gss == $past(hwdata[tcg_pkg::GSS_BIT]))
    else $error("gate source select not stored");

  gate_invert_a: assert property (@(posedge hclk) disable iff (!hresetn)
    inv && ge && run && !gate_raw && !wr_count |=> count_reg == $past(count_reg))
    else $error("inverted gate counted while low");

  internal_rate_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !cs && run && !ge && ps == 2'h0 && instr_tick && !wr_count && !$past(wr_ctrl)
    |=> ##3 count_reg == $past(count_reg, 4) + CNT_W'(1))
    else $error("instruction clock rate wrong");

  presc_range_a: assert property (@(posedge hclk) disable iff (!hresetn)
    count_en && src_tick && !wr_count && !wr_ctrl |=> presc_reg <= presc_last)
    else $error("prescaler beyond selected ratio");

  sync_align_a: assert property (@(posedge hclk) disable iff (!hresetn)
    cs && !sync_dis && presc_tick |-> instr_tick)
    else $error("synchronous count off instruction tick");

  ext_count_a: assert property (@(posedge hclk) disable iff (!hresetn)
    cs && sync_dis && run && !ge && ps == 2'h0 && ext_ok && !wr_count && !wr_ctrl
    |=> count_reg == $past(count_reg) + CNT_W'(1))
    else $error("asynchronous edge not counted");

  byte_read_a: assert property (@(posedge hclk) disable iff (!hresetn)
    addr_take && !hwrite && haddr[7:0] == tcg_pkg::CNT_HIGH_OFS
    |=> hrdata[7:0] == $past(count_reg[CNT_W-1 -: 8]))
    else $error("high byte read wrong");

  low_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_low |=> count_reg[7:0] == $past(hwdata[7:0]))
    else $error("low byte write lost");

endmodule // tcg_timer

// file: core/tcg_pkg.sv
// constants for the timer control and gate block
package tcg_pkg;
  localparam logic [7:0]  CTRL_OFS       = 8'h00;
  localparam logic [7:0]  CNT_LOW_OFS    = 8'h04;
  localparam logic [7:0]  CNT_HIGH_OFS   = 8'h08;
  localparam logic [7:0]  GATE_SEL_OFS   = 8'h0c;
  localparam logic [7:0]  CTRL_RESET     = 8'h00;
  localparam logic [7:0]  GATE_SEL_RESET = 8'h00;
  localparam logic [15:0] COUNT_RESET    = 16'h0000;
  // timer_control fields
  localparam int CTRL_RUN_BIT     = 0;
  localparam int CTRL_CS_BIT      = 1;
  localparam int CTRL_SYNCDIS_BIT = 2;
  localparam int CTRL_OSCEN_BIT   = 3;
  localparam int CTRL_PS_LSB      = 4;
  localparam int CTRL_GE_BIT      = 6;
  localparam int CTRL_INV_BIT     = 7;
  // comparator_two_control_b field
  localparam int GSS_BIT          = 1;
  // instruction clock is the system clock divided by four
  localparam logic [1:0] INSTR_DIV_LAST = 2'h3;
  localparam logic [1:0] HTRANS_NONSEQ  = 2'h2;
  localparam logic [1:0] HTRANS_SEQ     = 2'h3;
endpackage

// file: verif/tcg_pins_model.sv
// pin-side model: external count clock, gate pin and comparator level
`timescale 1ns/100ps
module tcg_pins_model (
  // clock
  input  wire logic hclk,
  // controls from the bench
  input  wire logic ext_run,
  input  wire logic gate_lvl,
  input  wire logic cmp_lvl,
  // pins toward the timer
  output logic      external_clock_pin,
  output logic      gate_pin_n,
  output logic      second_comparator_output
);
  logic [4:0] ph_reg;
  // 20-cycle clock, 10 low then 10 high; parked low when not in use
  always_ff @(posedge hclk) begin
    ph_reg             <= (!ext_run || ph_reg == 5'h13) ? 5'h00 : ph_reg + 5'h01;
    external_clock_pin <= ext_run && (ph_reg >= 5'h0a);
  end
  assign gate_pin_n               = gate_lvl;
  assign second_comparator_output = cmp_lvl;
endmodule // tcg_pins_model

// file: verif/timer1_control_and_gate_bench.sv
// self-checking bench for the timer control and gate block
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin error_cnt++; \
  $display("ERROR %s exp %h got %h", nm, e, g); end end
module timer1_control_and_gate_bench;
  logic        hclk, hresetn, hsel, hwrite, ext_run, gate_lvl, cmp_lvl;
  logic        hreadyout, hresp, lposc, ext_clk, gate_n, cmp;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [15:0] count_value, c0;
  int          error_cnt, n_compared;

  tcg_timer dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .external_clock_pin(ext_clk), .gate_pin_n(gate_n),
    .second_comparator_output(cmp), .low_power_osc_enable(lposc),
    .count_value(count_value));

  tcg_pins_model pins (.hclk(hclk), .ext_run(ext_run), .gate_lvl(gate_lvl),
    .cmp_lvl(cmp_lvl), .external_clock_pin(ext_clk), .gate_pin_n(gate_n),
    .second_comparator_output(cmp));

  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  task automatic summarize();
    if (error_cnt == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // one edge, then keep waiting while the slave stalls
  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (hreadyout !== 1'b1) begin
      error_cnt++;
      summarize();
    end
  endtask

  // single word transfer; read data left in rd
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= tcg_pkg::HTRANS_NONSEQ;
    haddr  <= {24'h0, a};
    hwrite <= wr;
    wait_rdy();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    rd = hrdata;
  endtask

  // count increments over 160 cycles under a given control value
  task automatic meas(input logic [7:0] ctl, input logic [15:0] exp);
    bus(1'b1, tcg_pkg::CTRL_OFS, {24'h0, ctl});
    repeat (40) @(posedge hclk);
    #1;
    c0 = count_value;
    repeat (160) @(posedge hclk);
    #1;
    `CHK("count delta", exp, 16'(count_value - c0))
  endtask

  initial begin
    repeat (100000) @(posedge hclk);
    error_cnt++;
    summarize();
  end

  initial begin
    hresetn  = 1'b0;
    hsel     = 1'b0;
    hwrite   = 1'b0;
    htrans   = 2'h0;
    hsize    = 3'h2;
    haddr    = 32'h0;
    hwdata   = 32'h0;
    ext_run  = 1'b0;
    gate_lvl = 1'b0;
    cmp_lvl  = 1'b0;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    bus(1'b0, tcg_pkg::CTRL_OFS, 32'h0);
    `CHK("ctrl reset", 32'h0, rd)
    `CHK("osc enable reset", 1'b0, lposc)
    bus(1'b1, tcg_pkg::CTRL_OFS, 32'h08);
    bus(1'b0, tcg_pkg::CTRL_OFS, 32'h0);
    `CHK("ctrl readback", 32'h08, rd)
    `CHK("osc enable", 1'b1, lposc)
    bus(1'b1, tcg_pkg::CNT_LOW_OFS, 32'h34);
    bus(1'b1, tcg_pkg::CNT_HIGH_OFS, 32'h12);
    bus(1'b0, tcg_pkg::CNT_LOW_OFS, 32'h0);
    `CHK("low byte", 32'h34, rd)
    bus(1'b0, tcg_pkg::CNT_HIGH_OFS, 32'h0);
    `CHK("high byte", 32'h12, rd)
    `CHK("count", 16'h1234, count_value)
    bus(1'b0, 8'h10, 32'h0);
    `CHK("unmapped", 32'h0, rd)
    `CHK("hresp", 1'b0, hresp)
    // internal clock, every prescale code
    for (int i = 0; i < 4; i++) begin
      meas({2'b00, 2'(i), 4'h1}, 16'd40 >> i);
    end
    meas(8'h00, 16'd0);
    meas(8'h05, 16'd40);
    gate_lvl <= 1'b1;
    meas(8'h41, 16'd0);
    meas(8'h01, 16'd40);
    meas(8'hc1, 16'd40);
    bus(1'b1, tcg_pkg::GATE_SEL_OFS, 32'h02);
    bus(1'b0, tcg_pkg::GATE_SEL_OFS, 32'h0);
    `CHK("gate select", 32'h02, rd)
    gate_lvl <= 1'b0;
    cmp_lvl  <= 1'b1;
    meas(8'h41, 16'd0);
    meas(8'hc1, 16'd40);
    bus(1'b1, tcg_pkg::GATE_SEL_OFS, 32'h00);
    meas(8'h41, 16'd40);
    // external clock, synchronised and not
    ext_run <= 1'b1;
    meas(8'h03, 16'd8);
    meas(8'h07, 16'd8);
    meas(8'h27, 16'd2);
    meas(8'h02, 16'd0);
    // reset with the timer stopped (run bit clear) clears control and count
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    bus(1'b0, tcg_pkg::CTRL_OFS, 32'h0);
    `CHK("ctrl after reset", 32'h0, rd)
    `CHK("count after reset", 16'h0000, count_value)
    summarize();
  end
endmodule // timer1_control_and_gate_bench
